//--- hw/key_scan_consts.vh
`ifndef KEY_SCAN_CONSTS_VH
`define KEY_SCAN_CONSTS_VH

// register offsets (byte addresses on the plain register port)
`define KS_ADDR_CTRL      4'h0
`define KS_ADDR_KEYS      4'h4
`define KS_ADDR_STATUS    4'h8

// control register fields
`define KS_CTRL_SLEEP_LSB 0
`define KS_CTRL_PIN_LSB   2
`define KS_CTRL_PORT_LSB  4
`define KS_CTRL_SEGOFF    6
`define KS_CTRL_RESET     7'h00

// status register fields
`define KS_STAT_SLEEPACK  0
`define KS_STAT_REQ       1
`define KS_STAT_BUSY      2

// matrix shape
`define KS_ROWS           6
`define KS_COLS           5
`define KS_KEYS           30

// timing, in oscillator periods T
`define KS_SCAN_T         9'd375
`define KS_ROW_T          6'd62
`define KS_REQ_T          10'd800

`endif

//--- hw/key_scan_sleep.v
/*
  Key-matrix scanner with debounce, key-read request line, sleep and wake
  control and reset-period pin states for a half-duty LCD driver.
  Assumes: CLK_IN much faster than the oscillator pin; the serial framing,
  display latch and LCD waveform logic sit outside and read the flags here.
*/
// What this block does
// - thirty key bits, index (row-1)*5+column, one while the key is held
// - rows routed to segment duty report their key bits as zero
// - sleep_ack is one when the press came in sleep, else zero
// - sleep stops the oscillator and drives segments and backplanes low
// - in sleep a press on a high row restarts oscillator and scan
// - each matrix scan lasts 375 oscillator periods
// - two agreeing scans pull the request low 800 periods after start
// - disagreeing scans with a key still down trigger another scan
// - in normal mode all scan rows stay high while idle
// - scan while any key is down; several presses give several bits
// - request line is released while chip enable is high
// - a finished key read releases the request and starts a new scan
// - power-on clear stops the basic clock
// - power-on clear blanks the display, the latch still loads
// - power-on clear resets the scan machine and disables scanning
// - power-on clear zeroes all key bits
// - power-on clear leaves the control registers untouched
// - during clear: shared pins segment low, row six high, request high
// - sleep_sel: 00 normal, 01 row six, 10 rows five-six, 11 all rows
// - scan_pin_sel: 00 thirty keys, 01 twenty-five keys, 1x twenty keys
`timescale 1ns/1ps
`include "key_scan_consts.vh"

module key_scan_sleep (
  input  wire        CLK_IN,
  input  wire        RESET_N_IN,
  input  wire        POWER_ON_CLEAR_N_IN,
  input  wire        TIMEBASE_PIN_IN,
  input  wire        CHIP_ENABLE_IN,
  input  wire [4:0]  SENSE_COLS_IN,
  input  wire [3:0]  REG_ADDR_IN,
  input  wire [31:0] REG_WDATA_IN,
  input  wire        REG_WR_IN,
  input  wire        REG_RD_IN,
  output reg  [31:0] REG_RDATA_OUT,
  output reg  [5:0]  SCAN_ROWS_OUT,
  output reg         SERIAL_OUT_REQUEST_OUT,
  output reg         SERIAL_OUT_REQUEST_OE_OUT,
  output reg         OSC_RUN_OUT,
  output reg         DISPLAY_BLANK_OUT,
  output reg  [1:0]  SHARED_ROW_SEG_OUT,
  output reg  [3:0]  PORT_GP_EN_OUT
);

  // ------------------------------------------------------------------
  // states
  // ------------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_SCAN = 4'h2;
  localparam [3:0] ST_WAIT = 4'h4;
  localparam [3:0] ST_HOLD = 4'h8;

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  reg       por_m_q, por_n_q;
  reg       ce_m_q, ce_q;
  reg [4:0] cols_m_q, cols_q;
  reg       tb_m_q, tb_q, tb_old_q;

  // two flops per outside pin, plus a third on the timebase for edge detect; logic reads the second flop and that third one
  always @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      por_m_q  <= 1'b0;
      por_n_q  <= 1'b0;
      ce_m_q   <= 1'b0;
      ce_q     <= 1'b0;
      cols_m_q <= 5'h00;
      cols_q   <= 5'h00;
      tb_m_q   <= 1'b0;
      tb_q     <= 1'b0;
      tb_old_q <= 1'b0;
    end else begin
      por_m_q  <= POWER_ON_CLEAR_N_IN;
      por_n_q  <= por_m_q;
      ce_m_q   <= CHIP_ENABLE_IN;
      ce_q     <= ce_m_q;
      cols_m_q <= SENSE_COLS_IN;
      cols_q   <= cols_m_q;
      tb_m_q   <= TIMEBASE_PIN_IN;
      tb_q     <= tb_m_q;
      tb_old_q <= tb_q;
    end
  end

  // one tick per oscillator period, only while the oscillator may run
  wire tick = tb_q & ~tb_old_q & OSC_RUN_OUT;

  // ------------------------------------------------------------------
  // control register
  // ------------------------------------------------------------------
  reg  [6:0] ctrl_q;
  wire [1:0] sleep_sel    = ctrl_q[`KS_CTRL_SLEEP_LSB +: 2];
  wire [1:0] scan_pin_sel = ctrl_q[`KS_CTRL_PIN_LSB +: 2];
  wire [1:0] port_sel     = ctrl_q[`KS_CTRL_PORT_LSB +: 2];
  wire       seg_off      = ctrl_q[`KS_CTRL_SEGOFF];
  wire       sleeping     = (sleep_sel != 2'b00);
  wire       wr_ctrl      = REG_WR_IN & (REG_ADDR_IN == `KS_ADDR_CTRL);
  wire       rd_keys      = REG_RD_IN & (REG_ADDR_IN == `KS_ADDR_KEYS);

  // only the system reset touches control; power-on clear must not
  always @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN)
      ctrl_q <= `KS_CTRL_RESET;
    else if (wr_ctrl)
      ctrl_q <= REG_WDATA_IN[6:0];
  end

  // rows that still act as scan rows
  reg [5:0] active_rows;
  reg [5:0] idle_rows;
  always @* begin
    case (scan_pin_sel)
      2'b00:   active_rows = 6'h3F;
      2'b01:   active_rows = 6'h3E;
      default: active_rows = 6'h3C;
    endcase
    case (sleep_sel)
      2'b00:   idle_rows = 6'h3F;
      2'b01:   idle_rows = 6'h20;
      2'b10:   idle_rows = 6'h30;
      default: idle_rows = 6'h3F;
    endcase
  end

  // column mask per row, so segment-duty rows never set key bits
  wire [4:0] row_mask;
  wire       row_live;

  // ------------------------------------------------------------------
  // scan state machine
  // ------------------------------------------------------------------
  reg [3:0]  state_q;
  reg [8:0]  phase_q;
  reg [5:0]  slot_q;
  reg [2:0]  row_q;
  reg        second_q;
  reg [9:0]  tcnt_q;
  reg [29:0] cur_q;
  reg [29:0] first_q;
  reg [29:0] keys_q;
  reg        sleep_ack_q;
  reg        req_q;

  assign row_live = (row_q < 3'd6) & active_rows[row_q];
  assign row_mask = row_live ? cols_q : 5'h00;

  wire any_key   = (cols_q != 5'h00);
  wire scan_end  = tick & (phase_q == `KS_SCAN_T - 9'd1);
  wire slot_end  = tick & (slot_q == `KS_ROW_T - 6'd1) & (row_q < 3'd6);
  wire [29:0] result = cur_q;

  // the whole key side is held in its initial state by power-on clear
  always @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_q     <= ST_IDLE;
      phase_q     <= 9'h000;
      slot_q      <= 6'h00;
      row_q       <= 3'h0;
      second_q    <= 1'b0;
      tcnt_q      <= 10'h000;
      cur_q       <= 30'h0;
      first_q     <= 30'h0;
      keys_q      <= 30'h0;
      sleep_ack_q <= 1'b0;
      req_q       <= 1'b0;
    end else if (!por_n_q) begin
      state_q     <= ST_IDLE;
      phase_q     <= 9'h000;
      slot_q      <= 6'h00;
      row_q       <= 3'h0;
      second_q    <= 1'b0;
      tcnt_q      <= 10'h000;
      cur_q       <= 30'h0;
      first_q     <= 30'h0;
      keys_q      <= 30'h0;
      sleep_ack_q <= 1'b0;
      req_q       <= 1'b0;
    end else begin
      // elapsed oscillator periods since the scan sequence began
      if (tick && tcnt_q != 10'h3FF)
        tcnt_q <= tcnt_q + 10'd1;
      // row slot walker inside one scan
      if (state_q == ST_SCAN && tick) begin
        phase_q <= scan_end ? 9'h000 : phase_q + 9'd1;
        if (scan_end) begin
          slot_q <= 6'h00;
          row_q  <= 3'h0;
        end else if (slot_q == `KS_ROW_T - 6'd1) begin
          slot_q <= 6'h00;
          if (row_q < 3'd6)
            row_q <= row_q + 3'd1;
        end else begin
          slot_q <= slot_q + 6'd1;
        end
      end
      if (state_q == ST_SCAN && slot_end)
        cur_q[row_q * 5 +: 5] <= row_mask;
      case (state_q)
        ST_IDLE: begin
          // idle rows are high, so a pressed key shows on some column
          if (any_key) begin
            state_q     <= ST_SCAN;
            sleep_ack_q <= sleeping;
            tcnt_q      <= 10'h000;
            phase_q     <= 9'h000;
            slot_q      <= 6'h00;
            row_q       <= 3'h0;
            second_q    <= 1'b0;
          end
        end
        ST_SCAN: begin
          if (scan_end) begin
            first_q <= result;
            if (!second_q) begin
              second_q <= 1'b1;
            end else if (result == first_q) begin
              keys_q <= result;
              // both scans empty: every key is up again
              state_q <= (result == 30'h0) ? ST_IDLE : ST_WAIT;
            end else if (result == 30'h0) begin
              state_q <= ST_IDLE;
            end
            // a disagreement with keys down compares against the next scan
          end
        end
        ST_WAIT: begin
          // the count starts at zero with the scan, so 800 ticks mean 800 T
          if (tcnt_q >= `KS_REQ_T) begin
            req_q   <= 1'b1;
            state_q <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // the controller's key read closes the request and rescans
          if (rd_keys) begin
            req_q    <= 1'b0;
            state_q  <= ST_SCAN;
            tcnt_q   <= 10'h000;
            phase_q  <= 9'h000;
            slot_q   <= 6'h00;
            row_q    <= 3'h0;
            second_q <= 1'b0;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // oscillator, display and pin drive
  // ------------------------------------------------------------------
  reg [5:0] scan_drive;
  reg [3:0] gp_en;
  always @* begin
    scan_drive = 6'h00;
    if (row_q < 3'd6)
      scan_drive[row_q] = 1'b1;
    case (port_sel)
      2'b00:   gp_en = 4'h0;
      2'b01:   gp_en = 4'h3;
      2'b10:   gp_en = 4'h7;
      default: gp_en = 4'hF;
    endcase
  end

  wire osc_on   = por_n_q & (~sleeping | (state_q != ST_IDLE) | any_key);
  wire in_scan  = (state_q == ST_SCAN);
  wire [5:0] run_rows = in_scan ? (scan_drive & active_rows)
                                : (idle_rows & active_rows);
  // during clear rows one and two fall to segment low, row six held high
  wire [5:0] clr_rows = {1'b1, idle_rows[4:2] & active_rows[4:2], 2'b00};

  // every pin comes from a flop; request pulls low only, never drives high
  always @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      SCAN_ROWS_OUT             <= 6'h20;
      SERIAL_OUT_REQUEST_OUT    <= 1'b0;
      SERIAL_OUT_REQUEST_OE_OUT <= 1'b0;
      OSC_RUN_OUT               <= 1'b0;
      DISPLAY_BLANK_OUT         <= 1'b1;
      SHARED_ROW_SEG_OUT        <= 2'b11;
      PORT_GP_EN_OUT            <= 4'h0;
    end else begin
      SERIAL_OUT_REQUEST_OUT    <= 1'b0;
      SERIAL_OUT_REQUEST_OE_OUT <= por_n_q & req_q & ~ce_q;
      OSC_RUN_OUT               <= osc_on;
      DISPLAY_BLANK_OUT         <= ~por_n_q | sleeping | seg_off;
      SCAN_ROWS_OUT             <= por_n_q ? run_rows : clr_rows;
      SHARED_ROW_SEG_OUT        <= por_n_q ? ~active_rows[1:0] : 2'b11;
      PORT_GP_EN_OUT            <= por_n_q ? gp_en : 4'h0;
    end
  end

  // ------------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------------
  // read data stand in the cycle after the strobe only
  always @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      REG_RDATA_OUT <= 32'h00000000;
    end else if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        `KS_ADDR_CTRL:   REG_RDATA_OUT <= {25'h0, ctrl_q};
        `KS_ADDR_KEYS:   REG_RDATA_OUT <= {2'b00, keys_q};
        `KS_ADDR_STATUS: REG_RDATA_OUT <= {29'h0, ~state_q[0], req_q, sleep_ack_q};
        default:         REG_RDATA_OUT <= 32'h00000000;
      endcase
    end else begin
      REG_RDATA_OUT <= 32'h00000000;
    end
  end

endmodule // key_scan_sleep

//--- sim/key_scan_monitor.sv
/*
  Port checker for the key scanner, bound onto its top module.
  Assumes one 40 MHz clock domain and an async active-low reset.
*/
`timescale 1ns/1ps
module key_scan_monitor (
  input logic        CLK_IN,
  input logic        RESET_N_IN,
  input logic        POWER_ON_CLEAR_N_IN,
  input logic        CHIP_ENABLE_IN,
  input logic [3:0]  REG_ADDR_IN,
  input logic        REG_RD_IN,
  input logic [31:0] REG_RDATA_OUT,
  input logic [5:0]  SCAN_ROWS_OUT,
  input logic        SERIAL_OUT_REQUEST_OUT,
  input logic        SERIAL_OUT_REQUEST_OE_OUT,
  input logic        OSC_RUN_OUT,
  input logic        DISPLAY_BLANK_OUT,
  input logic [1:0]  SHARED_ROW_SEG_OUT,
  input logic [3:0]  PORT_GP_EN_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  // five cycles of clear leave room for the two-flop synchroniser
  a_clear_pins: assert property ((!POWER_ON_CLEAR_N_IN) [*5] |->
    !SERIAL_OUT_REQUEST_OE_OUT && !OSC_RUN_OUT && DISPLAY_BLANK_OUT && SCAN_ROWS_OUT[5]
    && SHARED_ROW_SEG_OUT == 2'b11 && PORT_GP_EN_OUT == 4'h0) else $error("clear pin states");
  a_clear_keys: assert property ((!POWER_ON_CLEAR_N_IN) [*5] ##0
    (REG_RD_IN && REG_ADDR_IN == 4'h4) |=> REG_RDATA_OUT == 32'h0) else $error("keys not clear");
  a_req_drain: assert property (SERIAL_OUT_REQUEST_OUT == 1'b0)
    else $error("request data not low");
  a_ce_mask: assert property (CHIP_ENABLE_IN [*4] |-> !SERIAL_OUT_REQUEST_OE_OUT)
    else $error("request held during enable");
  a_read_clears: assert property ((REG_RD_IN && REG_ADDR_IN == 4'h4 &&
    SERIAL_OUT_REQUEST_OE_OUT && !CHIP_ENABLE_IN) |-> ##[1:3] !SERIAL_OUT_REQUEST_OE_OUT)
    else $error("request not cleared by read");
  a_rdata_idle: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == 32'h0)
    else $error("read data outside its cycle");
  a_keys_width: assert property (REG_RD_IN && REG_ADDR_IN == 4'h4 |=>
    REG_RDATA_OUT[31:30] == 2'b00) else $error("key word too wide");
  a_wake_osc: assert property ($rose(SERIAL_OUT_REQUEST_OE_OUT) |-> OSC_RUN_OUT)
    else $error("request without oscillator");
endmodule // key_scan_monitor

//--- sim/key_pad_model.sv
/*
  Keypad matrix of six rows by five columns with series diodes.
  Assumes pressed bit n-1 stands for key n, row-major, no ghost keys.
*/
`timescale 1ns/1ps
module key_pad_model (
  input  logic [5:0]  scan_rows,
  input  logic [29:0] pressed,
  output logic [4:0]  sense_cols
);
  // a column reads high only through a pressed key on a high row
  always_comb begin
    sense_cols = 5'h00;
    for (int r = 0; r < 6; r++)
      for (int c = 0; c < 5; c++)
        if (scan_rows[r] && pressed[r*5+c]) sense_cols[c] = 1'b1;
  end
endmodule // key_pad_model

//--- sim/test_key_scan_sleep.sv
/*
  Self-checking bench for the key scanner with a keypad model.
  Assumes oscillator pin of 200 ns, i.e. eight system clocks per T.
*/
`timescale 1ns/1ps
module test_key_scan_sleep;
  logic        clk = 0, rst_n = 0, poc_n = 0, osc = 0, ce = 0, wr = 0, rd = 0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, seed = 32'h27FACD48, d, v;
  logic [29:0] pressed = 30'h0;
  wire  [31:0] rdata;
  wire  [5:0]  rows;
  wire  [4:0]  cols;
  wire  [3:0]  gp;
  wire  [1:0]  seg;
  wire         req, req_oe, osc_run, blank;
  int          failures = 0, num_checks = 0;
  always #12.5 clk = ~clk;
  // oscillator phase kept unrelated to the system clock
  initial begin #37; forever #100 osc = ~osc; end
  key_scan_sleep i_key_scan_sleep (.CLK_IN(clk), .RESET_N_IN(rst_n), .POWER_ON_CLEAR_N_IN(poc_n),
    .TIMEBASE_PIN_IN(osc), .CHIP_ENABLE_IN(ce), .SENSE_COLS_IN(cols), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
    .SCAN_ROWS_OUT(rows), .SERIAL_OUT_REQUEST_OUT(req), .SERIAL_OUT_REQUEST_OE_OUT(req_oe),
    .OSC_RUN_OUT(osc_run), .DISPLAY_BLANK_OUT(blank), .SHARED_ROW_SEG_OUT(seg),
    .PORT_GP_EN_OUT(gp));
  key_pad_model i_key_pad_model (.scan_rows(rows), .pressed(pressed), .sense_cols(cols));
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13); seed = seed ^ (seed >> 17); seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // rows lent to segment duty read as zero keys
  function logic [31:0] exp_keys(logic [29:0] p, logic [1:0] pin);
    if (pin[1]) p[9:0] = 10'h000; else if (pin[0]) p[4:0] = 5'h00;
    return {2'b00, p};
  endfunction
  function logic [5:0] exp_rows(logic [1:0] s);
    return (s == 2'd1) ? 6'h20 : (s == 2'd2) ? 6'h30 : 6'h3F;
  endfunction
  function logic [3:0] exp_gp(logic [1:0] p);
    return (p == 2'd0) ? 4'h0 : (p == 2'd1) ? 4'h3 : (p == 2'd2) ? 4'h7 : 4'hF;
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task wreg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk); addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rreg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 v = rdata;
  endtask
  // press, wait for the request, mask it with enable, read, release, wait idle
  task key_cycle(input logic [29:0] p, input logic [1:0] pin, input logic sa);
    int cyc;
    cyc = 0;
    @(posedge clk); pressed <= p;
    while (req_oe !== 1'b1 && cyc < 20000) begin @(posedge clk); cyc++; end
    if (cyc >= 20000) begin check(32'h0, 32'h1); end_of_test(); end
    check(32'(cyc >= 6392 && cyc <= 6480), 32'h1);
    @(posedge clk); ce <= 1'b1;
    repeat (6) @(posedge clk);
    check(32'(req_oe), 32'h0);
    ce <= 1'b0;
    repeat (6) @(posedge clk);
    check(32'(req_oe), 32'h1);
    rreg(4'h8, d); check(32'(d[0]), 32'(sa));
    rreg(4'h4, d); check(d, exp_keys(p, pin));
    repeat (4) @(posedge clk);
    check(32'(req_oe), 32'h0);
    pressed <= 30'h0;
    cyc = 0;
    d = 32'h4;
    // status only is polled until the rescan settles; the request is not rechecked
    while (d[2] !== 1'b0 && cyc < 5000) begin rreg(4'h8, d); cyc++; end
    check(32'(d[2]), 32'h0);
    if (cyc >= 5000) begin check(32'h0, 32'h1); end_of_test(); end
  endtask
  initial begin
    #2400000;
    check(32'h0, 32'h1);
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // clear still low: control stays writable, key logic stays dead
    d = rnd() & 32'h7F;
    wreg(4'h0, d); rreg(4'h0, v); check(v, d);
    wreg(4'h4, 32'hFFFFFFFF);
    @(posedge clk); pressed <= 30'h3FFFFFFF;
    repeat (100) @(posedge clk);
    check(32'(osc_run), 32'h0);
    check(32'(blank), 32'h1);
    check({req_oe, rows[5], seg, gp}, {1'b0, 1'b1, 2'b11, 4'h0});
    rreg(4'h4, d); check(d, 32'h0);
    rreg(4'hC, d); check(d, 32'h0);
    @(posedge clk); pressed <= 30'h0;
    wreg(4'h0, 32'h0);
    @(posedge clk); poc_n <= 1'b1;
    repeat (10) @(posedge clk);
    check({rows, osc_run, blank}, {6'h3F, 1'b1, 1'b0});
    key_cycle(30'h1 << (rnd() % 30), 2'd0, 1'b0);
    key_cycle((30'h1 << (rnd() % 30)) | 30'h20000000, 2'd0, 1'b0);
    for (int k = 1; k < 3; k++) begin
      wreg(4'h0, 32'(k << 2));
      key_cycle(30'h00000221 | (30'h1 << (10 + rnd() % 20)), 2'(k), 1'b0);
    end
    for (int s = 1; s < 4; s++) begin
      wreg(4'h0, 32'(s | (s << 4)));
      repeat (10) @(posedge clk);
      check({rows, osc_run, blank, gp}, {exp_rows(2'(s)), 2'b01, exp_gp(2'(s))});
      key_cycle(30'h1 << (25 + rnd() % 5), 2'd0, 1'b1);
    end
    end_of_test();
  end
endmodule // test_key_scan_sleep

bind key_scan_sleep key_scan_monitor i_key_scan_monitor (.CLK_IN(CLK_IN),
  .RESET_N_IN(RESET_N_IN), .POWER_ON_CLEAR_N_IN(POWER_ON_CLEAR_N_IN),
  .CHIP_ENABLE_IN(CHIP_ENABLE_IN), .REG_ADDR_IN(REG_ADDR_IN), .REG_RD_IN(REG_RD_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT), .SCAN_ROWS_OUT(SCAN_ROWS_OUT),
  .SERIAL_OUT_REQUEST_OUT(SERIAL_OUT_REQUEST_OUT),
  .SERIAL_OUT_REQUEST_OE_OUT(SERIAL_OUT_REQUEST_OE_OUT), .OSC_RUN_OUT(OSC_RUN_OUT),
  .DISPLAY_BLANK_OUT(DISPLAY_BLANK_OUT), .SHARED_ROW_SEG_OUT(SHARED_ROW_SEG_OUT),
  .PORT_GP_EN_OUT(PORT_GP_EN_OUT));
